// ===== bench/tec_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================
// Port checker for the dual timer
module tec_chk
   import tec_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [7:0] rdata_o,
   input wire logic external_count_input_i,
   input wire logic low_speed_osc_clock_i,
   input wire logic timer_output_pin_o,
   input wire logic timer_output_en_o,
   input wire logic match_interrupt0_o,
   input wire logic match_interrupt1_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // Accepted bus cycles
   sequence s_wr(a); wr_en_i && clk_en_i && addr_i == a; endsequence
   sequence s_rd(a); rd_en_i && clk_en_i && addr_i == a; endsequence
   a_reset_quiet: assert property (disable iff (1'b0) !rst_n_i |=> rdata_o == 8'h00
      && !timer_output_pin_o && !timer_output_en_o && !match_interrupt0_o) else $error("reset");
   a_cmp_readback: assert property (s_wr(TEC_T0_CMP_ADDR) ##1 !wr_en_i ##1 s_rd(TEC_T0_CMP_ADDR)
      |=> rdata_o == $past(wdata_i, 3)) else $error("compare readback");
   a_sel_upper_zero: assert property (s_rd(TEC_T0_CLKSEL_ADDR)
      |=> rdata_o[7:3] == 5'h00) else $error("select upper bits");
   a_mode1_low_zero: assert property (s_rd(TEC_T1_MODE_ADDR)
      |=> rdata_o[5:0] == 6'h00) else $error("mode1 low bits");
   a_unmapped_zero: assert property (rd_en_i && clk_en_i && addr_i[15:8] != 8'hff
      |=> rdata_o == 8'h00) else $error("unmapped read");
   a_irq0_single: assert property (match_interrupt0_o && clk_en_i
      |=> !match_interrupt0_o) else $error("match0 width");
   a_irq1_single: assert property (match_interrupt1_o && clk_en_i
      |=> !match_interrupt1_o) else $error("match1 width");
   a_oe_follows: assert property (s_wr(TEC_T0_MODE_ADDR)
      |=> timer_output_en_o == $past(wdata_i[0])) else $error("output enable");
   a_pwm_idle: assert property (s_wr(TEC_T0_MODE_ADDR) ##0 wdata_i[7:6] == 2'b01
      ##1 clk_en_i && !(wr_en_i && addr_i == TEC_T0_MODE_ADDR)
      |=> timer_output_pin_o == $past(wdata_i[1] & wdata_i[0], 2)) else $error("pwm idle");
endmodule : tec_chk
bind tec_top tec_chk i_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rdata_o(rdata_o),
   .external_count_input_i(external_count_input_i), .low_speed_osc_clock_i(low_speed_osc_clock_i),
   .timer_output_pin_o(timer_output_pin_o), .timer_output_en_o(timer_output_en_o),
   .match_interrupt0_o(match_interrupt0_o), .match_interrupt1_o(match_interrupt1_o));
`default_nettype wire

// ===== bench/tec_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================
// Self-checking bench for the dual timer
module tec_top_bench
   import tec_pkg::*;
;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, wr_en = 1'b0, rd_en = 1'b0, ext = 1'b0, slow = 1'b0;
   logic ce = 1'b1;
   logic [15:0] addr = 16'h0;
   logic [7:0] wdata = 8'h0, rdata, cv;
   logic pin, oe, m0, m1, p;
   logic [31:0] seed = 32'h1bfe;
   int fail_count = 0, compares = 0, cyc = 0, hi = 0;
   int div0 [8] = '{0, 0, 2, 4, 16, 64, 256, 8192};
   // Last entry: slow clock rises every 2 cycles, divided by 128
   int div1 [8] = '{0, 0, 2, 32, 128, 1024, 8192, 256};
   tec_top i_tec_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .clk_en_i(ce), .addr_i(addr),
      .wdata_i(wdata), .wr_en_i(wr_en), .rd_en_i(rd_en), .rdata_o(rdata),
      .external_count_input_i(ext), .low_speed_osc_clock_i(slow), .timer_output_pin_o(pin),
      .timer_output_en_o(oe), .match_interrupt0_o(m0), .match_interrupt1_o(m1));
   always #10 mclk_i = ~mclk_i;
   // Slow oscillator toggles; hang guard
   always @(posedge mclk_i) begin
      #1 slow = ~slow;
      cyc++;
      if (cyc == 80000) begin
         fail_count++;
         close_out();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic step();
      @(posedge mclk_i);
      #1;
   endtask : step
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      step();
      wr_en = 1'b0;
      step();
   endtask : wr
   task automatic rdc(input string nm, input logic [15:0] a, input logic [7:0] e);
      addr = a;
      rd_en = 1'b1;
      step();
      rd_en = 1'b0;
      step();
      chk(nm, {8'h0, e}, {8'h0, rdata});
   endtask : rdc
   // Cycles between two match pulses
   task automatic per(input bit w, input int e);
      int n;
      n = 0;
      while (!(w ? m1 : m0) && n < 20000) begin
         step();
         n++;
      end
      n = 0;
      do begin
         step();
         n++;
      end while (!(w ? m1 : m0) && n < 20000);
      chk("period", e[15:0], n[15:0]);
   endtask : per
   task automatic close_out();
      if (fail_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (20) @(posedge mclk_i);
      #1 rst_n_i = 1'b1;
      for (int a = 0; a < 4; a++) begin
         rdc("reset0", 16'(TEC_T0_COUNT_ADDR + a), 8'h00);
         rdc("reset1", 16'(TEC_T1_COUNT_ADDR + a), 8'h00);
      end
      rdc("unmapped", 16'h1234, 8'h00);
      repeat (6) begin
         seed = lfsr(seed);
         wr(TEC_T0_CMP_ADDR, seed[7:0]);
         rdc("compare0", TEC_T0_CMP_ADDR, seed[7:0]);
         wr(TEC_T1_CMP_ADDR, seed[15:8]);
         rdc("compare1", TEC_T1_CMP_ADDR, seed[15:8]);
      end
      wr(TEC_T0_COUNT_ADDR, 8'ha5);
      rdc("count0", TEC_T0_COUNT_ADDR, 8'h00);
      wr(TEC_T0_CLKSEL_ADDR, 8'h06);
      rdc("select0", TEC_T0_CLKSEL_ADDR, 8'h06);
      // Interval period per clock code, both timers
      for (int w = 0; w < 2; w++) begin
         for (int c = 2; c < 8; c++) begin
            seed = lfsr(seed);
            cv = (c < 5) ? {5'h0, seed[2:0]} : 8'h00;
            wr(TEC_T0_MODE_ADDR + 16'(w * 16), 8'h00);
            wr(TEC_T0_CLKSEL_ADDR + 16'(w * 16), c[7:0]);
            wr(TEC_T0_CMP_ADDR + 16'(w * 16), cv);
            wr(TEC_T0_MODE_ADDR + 16'(w * 16), 8'h80);
            per(w[0], (int'(cv) + 1) * (w == 1 ? div1[c] : div0[c]));
         end
      end
      // Timer 1 code 1, which has no source, never counts
      wr(TEC_T1_MODE_ADDR, 8'h00);
      wr(TEC_T1_CLKSEL_ADDR, 8'h01);
      wr(TEC_T1_MODE_ADDR, 8'h80);
      repeat (20) step();
      rdc("idle1", TEC_T1_COUNT_ADDR, 8'h00);
      wr(TEC_T0_MODE_ADDR, 8'h00);
      wr(TEC_T0_CMP_ADDR, 8'hff);
      // Clock enable low: the write must not land
      ce = 1'b0;
      wr(TEC_T0_CMP_ADDR, 8'h3c);
      ce = 1'b1;
      rdc("frozen", TEC_T0_CMP_ADDR, 8'hff);
      // Pin edges: falling then rising code
      for (int c = 0; c < 2; c++) begin
         wr(TEC_T0_MODE_ADDR, 8'h00);
         wr(TEC_T0_CLKSEL_ADDR, c[7:0]);
         wr(TEC_T0_MODE_ADDR, 8'h80);
         ext = 1'b1;
         repeat (6) step();
         rdc("edge", TEC_T0_COUNT_ADDR, {7'h0, c[0]});
         ext = 1'b0;
         repeat (6) step();
         rdc("edge", TEC_T0_COUNT_ADDR, 8'h01);
      end
      wr(TEC_T0_MODE_ADDR, 8'h00);
      rdc("stopped", TEC_T0_COUNT_ADDR, 8'h00);
      // Square wave: strobes set and clear, matches toggle
      wr(TEC_T0_CLKSEL_ADDR, 8'h04);
      wr(TEC_T0_CMP_ADDR, 8'h03);
      wr(TEC_T0_MODE_ADDR, 8'h03);
      wr(TEC_T0_MODE_ADDR, 8'h0b);
      chk("set", 16'h1, {15'h0, pin});
      wr(TEC_T0_MODE_ADDR, 8'h07);
      chk("clear", 16'h0, {15'h0, pin});
      wr(TEC_T0_MODE_ADDR, 8'h83);
      per(1'b0, 64);
      p = pin;
      per(1'b0, 64);
      chk("toggle", {15'h0, !p}, {15'h0, pin});
      // PWM at fx/16: high from overflow to compare match
      seed = lfsr(seed);
      cv = {1'b0, seed[6:0]};
      wr(TEC_T0_MODE_ADDR, 8'h01);
      wr(TEC_T0_CMP_ADDR, cv);
      wr(TEC_T0_MODE_ADDR, 8'h41);
      wr(TEC_T0_MODE_ADDR, 8'hc1);
      repeat (4200) step();
      hi = 0;
      repeat (4096) begin
         step();
         hi += int'(pin);
      end
      chk("pwm high", 16'((int'(cv) + 1) * 16), hi[15:0]);
      wr(TEC_T0_MODE_ADDR, 8'h43);
      wr(TEC_T0_MODE_ADDR, 8'hc3);
      wr(TEC_T0_MODE_ADDR, 8'h43);
      chk("pwm idle", 16'h1, {15'h0, pin});
      chk("enable", 16'h1, {15'h0, oe});
      close_out();
   end
endmodule : tec_top_bench
`default_nettype wire

// ===== design/tec_channel.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// One 8-bit counter with compare, clear mode, PWM and output
// ============================================================
module tec_channel
   import tec_pkg::*;
#(
   parameter bit HAS_OUTPUT = 1'b1   // Square wave and PWM present
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic tick_i,           // One-cycle count clock edge
   input wire tec_ctrl_t ctrl_i,      // Mode control bits
   input wire logic ff_set_i,         // Output flip-flop set strobe
   input wire logic ff_clr_i,         // Output flip-flop reset strobe
   input wire logic [7:0] compare_i,  // Compare value
   output logic [7:0] count_o,        // Counter value
   output logic match_o,              // One-cycle match request
   output logic out_level_o           // Level for the timer pin
);

   logic [7:0] count_reg;   // Counter
   logic [7:0] count_next;
   logic match_reg;         // Registered match request
   logic match_next;
   logic tff_reg;           // Square-wave flip-flop
   logic tff_next;
   logic pff_reg;           // PWM flip-flop
   logic pff_next;
   logic cmp_eq;            // Counter equals compare
   logic ovf;               // Counter at top
   logic clr_match;         // Clearing match in clear mode

   // ==========================================================
   // Compare and next state
   // ==========================================================
   assign cmp_eq = (count_reg == compare_i);
   assign ovf = (count_reg == TEC_COUNT_MAX);
   assign clr_match = ctrl_i.run && tick_i && !ctrl_i.pwm && cmp_eq;

   // Stopped forces zero, match clears, otherwise tick advances
   assign count_next = !ctrl_i.run ? TEC_COUNT_RST :
                       clr_match ? TEC_COUNT_RST :
                       (ctrl_i.run && tick_i) ? count_reg + 8'h01 :
                       count_reg;

   // Match request only outside PWM, one cycle per tick
   assign match_next = clr_match;

   // Register strobes first, then toggle on match when invert is set
   assign tff_next = !HAS_OUTPUT ? 1'b0 :
                     (ff_set_i && !ctrl_i.pwm) ? 1'b1 :
                     (ff_clr_i && !ctrl_i.pwm) ? 1'b0 :
                     (clr_match && ctrl_i.invert) ? !tff_reg :
                     tff_reg;

   // Overflow makes active, match makes inactive, stop forces off
   assign pff_next = (!HAS_OUTPUT || !ctrl_i.run) ? 1'b0 :
                     (tick_i && ctrl_i.pwm && ovf) ? 1'b1 :
                     (tick_i && ctrl_i.pwm && cmp_eq) ? 1'b0 :
                     pff_reg;

   // ==========================================================
   // State registers
   // ==========================================================
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         count_reg <= TEC_COUNT_RST;
         match_reg <= 1'b0;
         tff_reg <= 1'b0;
         pff_reg <= 1'b0;
      end else if (clk_en_i) begin
         count_reg <= count_next;
         match_reg <= match_next;
         tff_reg <= tff_next;
         pff_reg <= pff_next;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign count_o = count_reg;
   assign match_o = match_reg;
   // Polarity applies in PWM mode only
   assign out_level_o = HAS_OUTPUT && ctrl_i.out_en &&
                        (ctrl_i.pwm ? (pff_reg ^ ctrl_i.invert) : tff_reg);

endmodule : tec_channel
`default_nettype wire

// ===== design/tec_top.sv
`timescale 1ns/1ps
`default_nettype none
module tec_top
   import tec_pkg::*;
(
   input wire logic mclk_i,                  // Main clock fx
   input wire logic rst_n_i,                 // Synchronous reset, active low
   input wire logic clk_en_i,                // Freezes all state while low
   input wire logic [15:0] addr_i,           // CPU byte address
   input wire logic [7:0] wdata_i,           // CPU write data
   input wire logic wr_en_i,                 // CPU write strobe
   input wire logic rd_en_i,                 // CPU read strobe
   output logic [7:0] rdata_o,               // CPU read data, registered
   input wire logic external_count_input_i,  // External event pin
   input wire logic low_speed_osc_clock_i,   // Low-speed oscillator level
   output logic timer_output_pin_o,          // Timer output pin level
   output logic timer_output_en_o,           // Timer output enable
   output logic match_interrupt0_o,          // Instance 0 match request
   output logic match_interrupt1_o           // Instance 1 match request
);

   // ==========================================================
   // Declarations
   // ==========================================================
   logic ext_s1_reg;                       // Pin synchroniser stage 1
   logic ext_s2_reg;                       // Pin synchroniser stage 2
   logic ext_prev_reg;                     // Previous synchronised pin level
   logic ls_s1_reg;                        // Low-speed clock stage 1
   logic ls_s2_reg;                        // Low-speed clock stage 2
   logic ls_prev_reg;                      // Previous low-speed level
   logic [TEC_PRESC_W-1:0] presc_reg;      // Main clock prescaler
   logic [TEC_PRESC_W-1:0] presc_next;
   logic [TEC_LS_DIV_W-1:0] ls_div_reg;    // Low-speed divider
   logic [TEC_LS_DIV_W-1:0] ls_div_next;
   logic [7:0] cmp0_reg;                   // compare_value_reg, instance 0
   logic [7:0] cmp1_reg;                   // compare_value_reg, instance 1
   logic [2:0] sel0_reg;                   // count_clock_select, instance 0
   logic [2:0] sel1_reg;                   // count_clock_select, instance 1
   tec_ctrl_t ctrl0_reg;                   // Mode control, instance 0
   tec_ctrl_t ctrl1_reg;                   // Mode control, instance 1
   tec_ctrl_t ctrl0_next;
   tec_ctrl_t ctrl1_next;
   logic [7:0] rdata_reg;                  // Registered read data
   logic [7:0] rdata_next;
   logic [7:0] count0;                     // timer_count_value, instance 0
   logic [7:0] count1;                     // timer_count_value, instance 1
   logic match0;                           // Match request, instance 0
   logic match1;                           // Match request, instance 1
   logic out_level0;                       // Pin level from instance 0
   logic out_level1;                       // Unused level from instance 1

   // ==========================================================
   // Address decode
   // ==========================================================
   logic wr_cmp0;      // Write compare 0
   logic wr_cmp1;      // Write compare 1
   logic wr_sel0;      // Write clock select 0
   logic wr_sel1;      // Write clock select 1
   logic wr_mode0;     // Write mode control 0
   logic wr_mode1;     // Write mode control 1
   logic ff_set0;      // Output flip-flop set strobe
   logic ff_clr0;      // Output flip-flop reset strobe

   assign wr_cmp0 = wr_en_i && (addr_i == TEC_T0_CMP_ADDR);
   assign wr_cmp1 = wr_en_i && (addr_i == TEC_T1_CMP_ADDR);
   assign wr_sel0 = wr_en_i && (addr_i == TEC_T0_CLKSEL_ADDR);
   assign wr_sel1 = wr_en_i && (addr_i == TEC_T1_CLKSEL_ADDR);
   assign wr_mode0 = wr_en_i && (addr_i == TEC_T0_MODE_ADDR);
   assign wr_mode1 = wr_en_i && (addr_i == TEC_T1_MODE_ADDR);

   // Both strobes at once is prohibited and treated as no change
   assign ff_set0 = wr_mode0 && clk_en_i && wdata_i[TEC_MODE_SET_BIT] &&
                    !wdata_i[TEC_MODE_CLR_BIT];
   assign ff_clr0 = wr_mode0 && clk_en_i && wdata_i[TEC_MODE_CLR_BIT] &&
                    !wdata_i[TEC_MODE_SET_BIT];

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   // Pin and low-speed clock each pass two flip-flops
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ext_s1_reg <= 1'b0;
         ext_s2_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
         ls_s1_reg <= 1'b0;
         ls_s2_reg <= 1'b0;
         ls_prev_reg <= 1'b0;
      end else if (clk_en_i) begin
         ext_s1_reg <= external_count_input_i;
         ext_s2_reg <= ext_s1_reg;
         ext_prev_reg <= ext_s2_reg;
         ls_s1_reg <= low_speed_osc_clock_i;
         ls_s2_reg <= ls_s1_reg;
         ls_prev_reg <= ls_s2_reg;
      end
   end

   // ==========================================================
   // Edge detection on synchronised levels
   // ==========================================================
   logic ext_rise;     // Pin rising edge
   logic ext_fall;     // Pin falling edge
   logic ls_rise;      // Low-speed clock rising edge

   assign ext_rise = ext_s2_reg && !ext_prev_reg;
   assign ext_fall = !ext_s2_reg && ext_prev_reg;
   assign ls_rise = ls_s2_reg && !ls_prev_reg;

   // ==========================================================
   // Prescalers
   // ==========================================================
   assign presc_next = presc_reg + {{(TEC_PRESC_W-1){1'b0}}, 1'b1};
   assign ls_div_next = ls_rise ? ls_div_reg + {{(TEC_LS_DIV_W-1){1'b0}}, 1'b1} :
                        ls_div_reg;

   // Free-running dividers of fx and of the low-speed clock
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         presc_reg <= '0;
         ls_div_reg <= '0;
      end else if (clk_en_i) begin
         presc_reg <= presc_next;
         ls_div_reg <= ls_div_next;
      end
   end

   // ==========================================================
   // Division taps, one cycle pulse per divided period
   // ==========================================================
   logic fx_d2;       // fx/2
   logic fx_d4;       // fx/4
   logic fx_d16;      // fx/16
   logic fx_d32;      // fx/32
   logic fx_d64;      // fx/64
   logic fx_d128;     // fx/128
   logic fx_d256;     // fx/256
   logic fx_d1024;    // fx/1024
   logic fx_d8192;    // fx/8192
   logic ls_d128;     // Low-speed clock / 128

   assign fx_d2 = &presc_reg[0:0];
   assign fx_d4 = &presc_reg[1:0];
   assign fx_d16 = &presc_reg[3:0];
   assign fx_d32 = &presc_reg[4:0];
   assign fx_d64 = &presc_reg[5:0];
   assign fx_d128 = &presc_reg[6:0];
   assign fx_d256 = &presc_reg[7:0];
   assign fx_d1024 = &presc_reg[9:0];
   assign fx_d8192 = &presc_reg[12:0];
   assign ls_d128 = ls_rise && (&ls_div_reg);

   // ==========================================================
   // Count clock selection
   // ==========================================================
   logic tick0;     // Count edge, instance 0
   logic tick1;     // Count edge, instance 1

   // Instance 0: pin edges or fx divisions
   assign tick0 = (sel0_reg == TEC_SEL_EXT_FALL) ? ext_fall :
                  (sel0_reg == TEC_SEL_EXT_RISE) ? ext_rise :
                  (sel0_reg == TEC_SEL_2) ? fx_d2 :
                  (sel0_reg == TEC_SEL_3) ? fx_d4 :
                  (sel0_reg == TEC_SEL_4) ? fx_d16 :
                  (sel0_reg == TEC_SEL_5) ? fx_d64 :
                  (sel0_reg == TEC_SEL_6) ? fx_d256 :
                  fx_d8192;

   // Instance 1: prohibited codes give no count edge
   assign tick1 = (sel1_reg == TEC_SEL_2) ? fx_d2 :
                  (sel1_reg == TEC_SEL_3) ? fx_d32 :
                  (sel1_reg == TEC_SEL_4) ? fx_d128 :
                  (sel1_reg == TEC_SEL_5) ? fx_d1024 :
                  (sel1_reg == TEC_SEL_6) ? fx_d8192 :
                  (sel1_reg == TEC_SEL_7) ? ls_d128 :
                  1'b0;

   // ==========================================================
   // Mode control next values
   // ==========================================================
   // Instance 1 keeps only run and mode bits
   assign ctrl0_next = wr_mode0 ?
                       '{run: wdata_i[TEC_MODE_RUN_BIT], pwm: wdata_i[TEC_MODE_PWM_BIT],
                         invert: wdata_i[TEC_MODE_INV_BIT],
                         out_en: wdata_i[TEC_MODE_OE_BIT]} :
                       ctrl0_reg;
   assign ctrl1_next = wr_mode1 ?
                       '{run: wdata_i[TEC_MODE_RUN_BIT], pwm: wdata_i[TEC_MODE_PWM_BIT],
                         invert: 1'b0, out_en: 1'b0} :
                       ctrl1_reg;

   // ==========================================================
   // Software registers
   // ==========================================================
   // Compare, clock select and mode control; counters not writable
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         cmp0_reg <= TEC_CMP_RST;
         cmp1_reg <= TEC_CMP_RST;
         sel0_reg <= TEC_CLKSEL_RST;
         sel1_reg <= TEC_CLKSEL_RST;
         ctrl0_reg <= '0;
         ctrl1_reg <= '0;
      end else if (clk_en_i) begin
         if (wr_cmp0) begin
            cmp0_reg <= wdata_i;
         end
         if (wr_cmp1) begin
            cmp1_reg <= wdata_i;
         end
         if (wr_sel0) begin
            sel0_reg <= wdata_i[TEC_CLKSEL_W-1:0];
         end
         if (wr_sel1) begin
            sel1_reg <= wdata_i[TEC_CLKSEL_W-1:0];
         end
         ctrl0_reg <= ctrl0_next;
         ctrl1_reg <= ctrl1_next;
      end
   end

   // ==========================================================
   // Read multiplexer
   // ==========================================================
   logic [7:0] mode0_rd;   // Mode 0 readback, strobes read zero
   logic [7:0] mode1_rd;   // Mode 1 readback, low bits zero

   assign mode0_rd = {ctrl0_reg.run, ctrl0_reg.pwm, 4'h0,
                      ctrl0_reg.invert, ctrl0_reg.out_en};
   assign mode1_rd = {ctrl1_reg.run, ctrl1_reg.pwm, 6'h00};

   // Unmapped addresses read zero
   assign rdata_next = !rd_en_i ? rdata_reg :
                       (addr_i == TEC_T0_COUNT_ADDR) ? count0 :
                       (addr_i == TEC_T0_CMP_ADDR) ? cmp0_reg :
                       (addr_i == TEC_T0_CLKSEL_ADDR) ? {5'h00, sel0_reg} :
                       (addr_i == TEC_T0_MODE_ADDR) ? mode0_rd :
                       (addr_i == TEC_T1_COUNT_ADDR) ? count1 :
                       (addr_i == TEC_T1_CMP_ADDR) ? cmp1_reg :
                       (addr_i == TEC_T1_CLKSEL_ADDR) ? {5'h00, sel1_reg} :
                       (addr_i == TEC_T1_MODE_ADDR) ? mode1_rd :
                       8'h00;

   // Read data held until the next read
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rdata_reg <= TEC_RDATA_RST;
      end else if (clk_en_i) begin
         rdata_reg <= rdata_next;
      end
   end

   // ==========================================================
   // Channels
   // ==========================================================
   // Instance 0 with pin features
   tec_channel #(
      .HAS_OUTPUT(1'b1)
   ) u_chan0 (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .tick_i(tick0),
      .ctrl_i(ctrl0_reg),
      .ff_set_i(ff_set0),
      .ff_clr_i(ff_clr0),
      .compare_i(cmp0_reg),
      .count_o(count0),
      .match_o(match0),
      .out_level_o(out_level0)
   );

   // Instance 1, interval timing only
   tec_channel #(
      .HAS_OUTPUT(1'b0)
   ) u_chan1 (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .tick_i(tick1),
      .ctrl_i(ctrl1_reg),
      .ff_set_i(1'b0),
      .ff_clr_i(1'b0),
      .compare_i(cmp1_reg),
      .count_o(count1),
      .match_o(match1),
      .out_level_o(out_level1)
   );

   // ==========================================================
   // Outputs
   // ==========================================================
   assign rdata_o = rdata_reg;
   assign match_interrupt0_o = match0;
   assign match_interrupt1_o = match1;
   assign timer_output_pin_o = out_level0;
   assign timer_output_en_o = ctrl0_reg.out_en;

   // Instance 1 level is held at zero by construction
   logic unused_level;
   assign unused_level = out_level1;

endmodule : tec_top
`default_nettype wire

// ===== include/tec_pkg.sv
// ============================================================
// Shared constants and types for the dual 8-bit timer block
// ============================================================
package tec_pkg;

   // ==========================================================
   // Register byte addresses
   // ==========================================================
   localparam logic [15:0] TEC_T0_COUNT_ADDR = 16'hff2c;   // Counter 0, read only
   localparam logic [15:0] TEC_T0_CMP_ADDR = 16'hff2d;     // Compare 0
   localparam logic [15:0] TEC_T0_CLKSEL_ADDR = 16'hff2e;  // Clock select 0
   localparam logic [15:0] TEC_T0_MODE_ADDR = 16'hff2f;    // Mode control 0
   localparam logic [15:0] TEC_T1_COUNT_ADDR = 16'hff3c;   // Counter 1, read only
   localparam logic [15:0] TEC_T1_CMP_ADDR = 16'hff3d;     // Compare 1
   localparam logic [15:0] TEC_T1_CLKSEL_ADDR = 16'hff3e;  // Clock select 1
   localparam logic [15:0] TEC_T1_MODE_ADDR = 16'hff3f;    // Mode control 1

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [7:0] TEC_COUNT_RST = 8'h00;   // Counter after reset
   localparam logic [7:0] TEC_CMP_RST = 8'h00;     // Compare after reset
   localparam logic [2:0] TEC_CLKSEL_RST = 3'h0;   // Clock select after reset
   localparam logic [7:0] TEC_RDATA_RST = 8'h00;   // Read data after reset
   localparam logic [7:0] TEC_COUNT_MAX = 8'hff;   // Overflow point

   // ==========================================================
   // Mode control field positions
   // ==========================================================
   localparam int TEC_MODE_RUN_BIT = 7;   // count_run_enable
   localparam int TEC_MODE_PWM_BIT = 6;   // pwm_mode_select
   localparam int TEC_MODE_SET_BIT = 3;   // Output flip-flop set strobe
   localparam int TEC_MODE_CLR_BIT = 2;   // Output flip-flop reset strobe
   localparam int TEC_MODE_INV_BIT = 1;   // output_invert_or_polarity
   localparam int TEC_MODE_OE_BIT = 0;    // Timer output enable
   localparam int TEC_CLKSEL_W = 3;       // Width of clock select field

   // ==========================================================
   // Clock select codes
   // ==========================================================
   localparam logic [2:0] TEC_SEL_EXT_FALL = 3'h0;  // Instance 0 pin falling
   localparam logic [2:0] TEC_SEL_EXT_RISE = 3'h1;  // Instance 0 pin rising
   localparam logic [2:0] TEC_SEL_2 = 3'h2;         // fx/2 on both
   localparam logic [2:0] TEC_SEL_3 = 3'h3;
   localparam logic [2:0] TEC_SEL_4 = 3'h4;
   localparam logic [2:0] TEC_SEL_5 = 3'h5;
   localparam logic [2:0] TEC_SEL_6 = 3'h6;
   localparam logic [2:0] TEC_SEL_7 = 3'h7;

   // ==========================================================
   // Divider sizes
   // ==========================================================
   localparam int TEC_PRESC_W = 13;   // Main clock prescaler up to fx/8192
   localparam int TEC_LS_DIV_W = 7;   // Low-speed clock divider of 128

   // Mode control bits carried to a channel
   typedef struct packed {
      logic run;      // count_run_enable
      logic pwm;      // pwm_mode_select
      logic invert;   // output_invert_or_polarity
      logic out_en;   // Timer output enable
   } tec_ctrl_t;

endpackage : tec_pkg
